// File: apc_defs.svh
`ifndef APC_DEFS_SVH
`define APC_DEFS_SVH

// register indices; byte address is four times the index
`define APC_IDX_CTRL 16'h1D26
`define APC_IDX_PCFG 16'h1D27
`define APC_IDX_CFG3 16'h1D29
`define APC_IDX_PRET 16'h1D30
`define APC_IDX_RES 16'h1D31
`define APC_IDX_THR 16'h1D32
`define APC_IDX_STAT 16'h1D33
`define APC_IDX_MASK 16'h1D34

// control register fields
`define APC_CTRL_ON 7
`define APC_CTRL_CONTINUOUS_ENABLE 6
`define APC_CTRL_GO 0
// precharge configuration fields
`define APC_PCFG_PRECHARGE_POLARITY 7
`define APC_PCFG_INVERTED_PRECHARGE_ENABLE 6
`define APC_PCFG_GUARD_POLARITY 5
`define APC_PCFG_PRECHARGE_CAP_ONLY 1
`define APC_PCFG_DOUBLE_SAMPLE_ENABLE 0
// configuration 3 field
`define APC_CFG3_SOI 3
// status and mask fields
`define APC_ST_CONV 0
`define APC_ST_THR 1
`define APC_ST_W 2

// widths and reset values
`define APC_REG_W 8
`define APC_RES_W 10
`define APC_BYTE_RST 8'h00
`define APC_OKAY 2'h0
`define APC_SLVERR 2'h2

`endif

// File: apc_pkg.sv
package apc_pkg;
`include "apc_defs.svh"

	// conversion sequencer states
	typedef enum logic [1:0] {ST_IDLE, ST_PRE, ST_ACQ, ST_CONV} apc_state_e;

	// one register write handed from the bus slave to the register file
	typedef struct packed {
		logic valid;
		logic [17:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} apc_wreq_s;

	// precharge configuration fields
	typedef struct packed {
		logic precharge_polarity;
		logic inverted_precharge_enable;
		logic guard_polarity;
		logic precharge_cap_only;
		logic double_sample_enable;
	} apc_pcfg_s;
endpackage : apc_pkg

// File: apc_sync2.sv
`timescale 1ns/1ps
// two-flop synchroniser for levels arriving from the analog side
module apc_sync2 #(
	parameter int W = 1
) (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] meta_q; // first stage, read only by the second

	// both stages
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			meta_q <= '0;
			sync_o <= '0;
		end
		else
		begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end
endmodule : apc_sync2

// File: apc_axil_slave.sv
`timescale 1ns/1ps
`include "apc_defs.svh"
// axi4-lite slave front end: one write and one read in flight
module apc_axil_slave
	import apc_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [17:0] s_axi_awaddr_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	output logic [1:0] s_axi_bresp_o,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	input wire logic [17:0] s_axi_araddr_i,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output apc_wreq_s wr_o,
	input wire logic wr_ok_i,
	output logic [17:0] rd_addr_o,
	output logic rd_en_o,
	input wire logic [31:0] rd_data_i,
	input wire logic rd_ok_i
);
	logic [17:0] waddr_q; // captured write address
	logic [31:0] wdata_q; // captured write data
	logic [3:0] wstrb_q; // captured strobes
	logic rpend_q; // read address taken, read response not yet accepted
	logic wfire; // both halves held, response not yet out

	// ready low means the channel item is held here
	assign wfire = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;
	assign wr_o = '{valid: wfire, addr: waddr_q, data: wdata_q, strb: wstrb_q};
	assign rd_en_o = rpend_q && !s_axi_rvalid_o;

	////////////////////////////////////////////////////////////////////////
	// write channels: address and data taken in either order
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o <= 1'b1;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= `APC_OKAY;
			waddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end
		else
		begin
			if (s_axi_awvalid_i && s_axi_awready_o)
			begin
				waddr_q <= s_axi_awaddr_i;
				s_axi_awready_o <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o)
			begin
				wdata_q <= s_axi_wdata_i;
				wstrb_q <= s_axi_wstrb_i;
				s_axi_wready_o <= 1'b0;
			end
			// unmapped address answers slverr
			if (wfire)
			begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= wr_ok_i ? `APC_OKAY : `APC_SLVERR;
			end
			else if (s_axi_bvalid_o && s_axi_bready_i)
			begin
				s_axi_bvalid_o <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read channels: data registered one cycle after the address
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			s_axi_arready_o <= 1'b1;
			rpend_q <= 1'b0;
			rd_addr_o <= '0;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= '0;
			s_axi_rresp_o <= `APC_OKAY;
		end
		else
		begin
			if (s_axi_arvalid_i && s_axi_arready_o)
			begin
				rd_addr_o <= s_axi_araddr_i;
				s_axi_arready_o <= 1'b0;
				rpend_q <= 1'b1;
			end
			if (rd_en_o)
			begin
				s_axi_rvalid_o <= 1'b1;
				s_axi_rdata_o <= rd_data_i;
				s_axi_rresp_o <= rd_ok_i ? `APC_OKAY : `APC_SLVERR;
			end
			else if (s_axi_rvalid_o && s_axi_rready_i)
			begin
				s_axi_rvalid_o <= 1'b0;
				rpend_q <= 1'b0;
				s_axi_arready_o <= 1'b1;
			end
		end
	end
endmodule : apc_axil_slave

// File: apc_top.sv
// Operation
// - go bit reads zero when idle
// - go only starts while module is on
// - abort saves partial result, resets sequencer
// - abort sets no flag, skips computation
// - precharge polarity drives pin and capacitor oppositely
// - inverted precharge flips second double-sample cycle
// - guard ring starts at guard polarity
// - capacitor-only precharge leaves pin undriven
// - precharge config layout, read/write, resets zero
// - double sampling computes after each pair
// - continuous mode retriggers until stopped
`timescale 1ns/1ps
`include "apc_defs.svh"
module apc_top
	import apc_pkg::*;
#(
	parameter int CLK_DIV = 4, // reference cycles per converter tick
	parameter int ACQ_TICKS = 8, // acquisition length in ticks
	parameter int RES_W = `APC_RES_W // result width
) (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [17:0] s_axi_awaddr_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	output logic [1:0] s_axi_bresp_o,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	input wire logic [17:0] s_axi_araddr_i,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	input wire logic comp_i, // comparator: input above trial code
	output logic [RES_W-1:0] sar_code_o, // trial code to the capacitor dac
	output logic sample_o, // sampling switch closed
	output logic cap_pre_o, // sample capacitor precharge switch on
	output logic cap_level_o, // capacitor precharge level, 1 = supply
	output logic pin_o, // analog pin precharge level
	output logic pin_oe_o, // analog pin driven
	output logic guard_o, // guard ring level
	output logic irq_o
);
	apc_wreq_s wr; // write from bus slave
	logic [17:0] rd_addr; // read address held by bus slave
	logic rd_en; // one-cycle read fetch
	logic [31:0] rd_data; // read mux
	logic comp_s; // synchronised comparator
	logic on_q, continuous_enable_q, go_q, soi_q; // control bits
	apc_pcfg_s pcfg_q; // precharge configuration
	logic [`APC_REG_W-1:0] pre_time_q; // precharge ticks
	logic [RES_W-1:0] thr_q, res_q, first_q; // threshold, result, first of pair
	logic [RES_W-1:0] sar_q, bit_q; // approximation and current trial bit
	logic [`APC_ST_W-1:0] stat_q, mask_q; // sticky flags and mask
	apc_state_e state_q;
	logic [`APC_REG_W-1:0] cnt_q; // ticks spent in current stage
	logic [$clog2(CLK_DIV+1)-1:0] div_q; // tick divider
	logic tick; // one-cycle converter tick
	logic second_q; // second conversion of a pair running
	logic wr_ctrl, go_set, go_clr, abort, done, pair_end, thr_hit, stop;
	logic [RES_W-1:0] sar_next, partial;
	logic [`APC_ST_W-1:0] ev, rd_clr;
	logic pol, guard_polarity; // effective precharge and guard polarity
	apc_state_e start_st;

	// register index of a byte address
	function automatic logic [15:0] reg_idx(input logic [17:0] a);
		reg_idx = a[17:2];
	endfunction : reg_idx

	// mapped register test, used for both bus directions
	function automatic logic reg_hit(input logic [17:0] a);
		logic [15:0] i;
		i = reg_idx(a);
		reg_hit = (i == `APC_IDX_CTRL) || (i == `APC_IDX_PCFG) || (i == `APC_IDX_CFG3) ||
			(i == `APC_IDX_PRET) || (i == `APC_IDX_RES) || (i == `APC_IDX_THR) ||
			(i == `APC_IDX_STAT) || (i == `APC_IDX_MASK);
	endfunction : reg_hit

	////////////////////////////////////////////////////////////////////////
	// bus slave and comparator synchroniser
	apc_axil_slave u_bus (
		.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i),
		.s_axi_awvalid_i(s_axi_awvalid_i),
		.s_axi_awready_o(s_axi_awready_o),
		.s_axi_awaddr_i(s_axi_awaddr_i),
		.s_axi_wvalid_i(s_axi_wvalid_i),
		.s_axi_wready_o(s_axi_wready_o),
		.s_axi_wdata_i(s_axi_wdata_i),
		.s_axi_wstrb_i(s_axi_wstrb_i),
		.s_axi_bvalid_o(s_axi_bvalid_o),
		.s_axi_bready_i(s_axi_bready_i),
		.s_axi_bresp_o(s_axi_bresp_o),
		.s_axi_arvalid_i(s_axi_arvalid_i),
		.s_axi_arready_o(s_axi_arready_o),
		.s_axi_araddr_i(s_axi_araddr_i),
		.s_axi_rvalid_o(s_axi_rvalid_o),
		.s_axi_rready_i(s_axi_rready_i),
		.s_axi_rdata_o(s_axi_rdata_o),
		.s_axi_rresp_o(s_axi_rresp_o),
		.wr_o(wr),
		.wr_ok_i(reg_hit(wr.addr)),
		.rd_addr_o(rd_addr),
		.rd_en_o(rd_en),
		.rd_data_i(rd_data),
		.rd_ok_i(reg_hit(rd_addr))
	);

	apc_sync2 #(.W(1)) u_comp (
		.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i),
		.async_i(comp_i),
		.sync_o(comp_s)
	);

	////////////////////////////////////////////////////////////////////////
	// decode and sequencer terms
	// writes are gated by strobe bit 0 only
	assign wr_ctrl = wr.valid && wr.strb[0] && (reg_idx(wr.addr) == `APC_IDX_CTRL);
	assign go_set = wr_ctrl && wr.data[`APC_CTRL_GO] && on_q;
	assign go_clr = wr_ctrl && !wr.data[`APC_CTRL_GO];
	// clearing go, or switching off, while busy is an abort
	assign abort = go_q && (go_clr || !on_q);
	assign tick = (div_q == ($bits(div_q))'(CLK_DIV - 1));
	assign sar_next = comp_s ? sar_q : (sar_q & ~bit_q);
	assign done = (state_q == ST_CONV) && tick && bit_q[0] && !abort;
	// with double sampling only the second of a pair completes the trigger
	assign pair_end = done && (!pcfg_q.double_sample_enable || second_q);
	assign thr_hit = pair_end && (sar_next > thr_q);
	assign stop = !continuous_enable_q || (soi_q && (thr_hit || stat_q[`APC_ST_THR]));
	// undecided trial bit is dropped from an aborted result
	assign partial = (state_q == ST_CONV) ? (sar_q & ~bit_q) : '0;
	// zero precharge time skips the stage, so polarity has no effect
	assign start_st = (pre_time_q != `APC_BYTE_RST) ? ST_PRE : ST_ACQ;
	assign pol = pcfg_q.precharge_polarity ^ (pcfg_q.double_sample_enable && pcfg_q.inverted_precharge_enable && second_q);
	assign guard_polarity = pcfg_q.guard_polarity ^ (pcfg_q.double_sample_enable && pcfg_q.inverted_precharge_enable && second_q);
	// flags are only raised by a finished trigger, never by an abort
	assign ev = {thr_hit, pair_end};
	assign rd_clr = (rd_en && reg_idx(rd_addr) == `APC_IDX_STAT) ? stat_q : '0;

	////////////////////////////////////////////////////////////////////////
	// configuration registers
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			on_q <= 1'b0;
			continuous_enable_q <= 1'b0;
			soi_q <= 1'b0;
			pcfg_q <= '0;
			pre_time_q <= `APC_BYTE_RST;
			thr_q <= '0;
			mask_q <= '0;
		end
		else if (wr.valid && wr.strb[0])
		begin
			unique case (reg_idx(wr.addr))
				`APC_IDX_CTRL:
				begin
					on_q <= wr.data[`APC_CTRL_ON];
					continuous_enable_q <= wr.data[`APC_CTRL_CONTINUOUS_ENABLE];
				end
				// bits 4..2 have no storage
				`APC_IDX_PCFG: pcfg_q <= {wr.data[`APC_PCFG_PRECHARGE_POLARITY], wr.data[`APC_PCFG_INVERTED_PRECHARGE_ENABLE],
					wr.data[`APC_PCFG_GUARD_POLARITY], wr.data[`APC_PCFG_PRECHARGE_CAP_ONLY], wr.data[`APC_PCFG_DOUBLE_SAMPLE_ENABLE]};
				`APC_IDX_CFG3: soi_q <= wr.data[`APC_CFG3_SOI];
				`APC_IDX_PRET: pre_time_q <= wr.data[`APC_REG_W-1:0];
				`APC_IDX_THR: thr_q <= wr.data[RES_W-1:0];
				`APC_IDX_MASK: mask_q <= wr.data[`APC_ST_W-1:0];
				default: ; // read-only or unmapped
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read mux; unused bits read zero
	always_comb
	begin
		rd_data = '0;
		unique case (reg_idx(rd_addr))
			`APC_IDX_CTRL:
			begin
				rd_data[`APC_CTRL_ON] = on_q;
				rd_data[`APC_CTRL_CONTINUOUS_ENABLE] = continuous_enable_q;
				rd_data[`APC_CTRL_GO] = go_q;
			end
			`APC_IDX_PCFG:
			begin
				rd_data[`APC_PCFG_PRECHARGE_POLARITY] = pcfg_q.precharge_polarity;
				rd_data[`APC_PCFG_INVERTED_PRECHARGE_ENABLE] = pcfg_q.inverted_precharge_enable;
				rd_data[`APC_PCFG_GUARD_POLARITY] = pcfg_q.guard_polarity;
				rd_data[`APC_PCFG_PRECHARGE_CAP_ONLY] = pcfg_q.precharge_cap_only; // gap stays zero
				rd_data[`APC_PCFG_DOUBLE_SAMPLE_ENABLE] = pcfg_q.double_sample_enable;
			end
			`APC_IDX_CFG3: rd_data[`APC_CFG3_SOI] = soi_q;
			`APC_IDX_PRET: rd_data[`APC_REG_W-1:0] = pre_time_q;
			`APC_IDX_RES: rd_data[RES_W-1:0] = res_q;
			`APC_IDX_THR: rd_data[RES_W-1:0] = thr_q;
			`APC_IDX_STAT: rd_data[`APC_ST_W-1:0] = stat_q;
			`APC_IDX_MASK: rd_data[`APC_ST_W-1:0] = mask_q;
			default: rd_data = '0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// converter tick divider, restarted by each go write while on, not by continuous retriggers
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			div_q <= '0;
		else if (go_set || tick)
			div_q <= '0;
		else
			div_q <= div_q + 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// conversion sequencer: go bit, stages, approximation, result
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			state_q <= ST_IDLE;
			go_q <= 1'b0;
			second_q <= 1'b0;
			cnt_q <= '0;
			sar_q <= '0;
			bit_q <= '0;
			res_q <= '0;
			first_q <= '0;
		end
		else if (abort)
		begin
			// partial result kept, no flags, sequencer reset
			res_q <= partial;
			state_q <= ST_IDLE;
			go_q <= 1'b0;
			second_q <= 1'b0;
			sar_q <= '0;
			bit_q <= '0;
		end
		else
		begin
			unique case (state_q)
				ST_IDLE:
					if (go_set)
					begin
						go_q <= 1'b1;
						state_q <= start_st;
						cnt_q <= '0;
					end
				ST_PRE:
					if (tick)
					begin
						cnt_q <= (cnt_q == pre_time_q - 1'b1) ? '0 : cnt_q + 1'b1;
						if (cnt_q == pre_time_q - 1'b1)
							state_q <= ST_ACQ;
					end
				ST_ACQ:
					if (tick)
					begin
						cnt_q <= (cnt_q == (`APC_REG_W)'(ACQ_TICKS - 1)) ? '0 : cnt_q + 1'b1;
						if (cnt_q == (`APC_REG_W)'(ACQ_TICKS - 1))
						begin
							state_q <= ST_CONV;
							bit_q <= {1'b1, {(RES_W-1){1'b0}}};
							sar_q <= {1'b1, {(RES_W-1){1'b0}}};
						end
					end
				ST_CONV:
					if (tick && !bit_q[0])
					begin
						bit_q <= bit_q >> 1;
						sar_q <= sar_next | (bit_q >> 1);
					end
					else if (done)
					begin
						res_q <= sar_next;
						sar_q <= '0;
						bit_q <= '0;
						cnt_q <= '0;
						if (!pair_end)
						begin
							// first of a pair: keep it, run the second
							first_q <= sar_next;
							second_q <= 1'b1;
							state_q <= start_st;
						end
						else if (stop)
						begin
							second_q <= 1'b0;
							go_q <= 1'b0;
							state_q <= ST_IDLE;
						end
						else
						begin
							second_q <= 1'b0;
							state_q <= start_st;
						end
					end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sticky flags; a new event wins over a read clear
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			stat_q <= '0;
			irq_o <= 1'b0;
		end
		else
		begin
			stat_q <= (stat_q & ~rd_clr) | ev;
			irq_o <= |(((stat_q & ~rd_clr) | ev) & mask_q);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// analog switch outputs, registered from stage and polarity
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			cap_pre_o <= 1'b0;
			cap_level_o <= 1'b0;
			pin_o <= 1'b0;
			pin_oe_o <= 1'b0;
			guard_o <= 1'b0;
			sample_o <= 1'b0;
			sar_code_o <= '0;
		end
		else
		begin
			cap_pre_o <= (state_q == ST_PRE);
			cap_level_o <= (state_q == ST_PRE) && !pol;
			pin_oe_o <= (state_q == ST_PRE) && !pcfg_q.precharge_cap_only;
			pin_o <= (state_q == ST_PRE) && !pcfg_q.precharge_cap_only && pol;
			// guard starts at its polarity and holds through the cycle
			guard_o <= (state_q != ST_IDLE) && guard_polarity;
			sample_o <= (state_q == ST_ACQ);
			sar_code_o <= sar_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	sequence pre_seq;
		state_q == ST_PRE;
	endsequence

	sequence abort_seq;
		abort;
	endsequence

	go_idle_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) (state_q == ST_IDLE) == !go_q)
		else $error("go bit disagrees with sequencer");
	go_on_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) $rose(go_q) |-> $past(on_q))
		else $error("conversion started while off");
	abort_result_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		abort_seq |=> (state_q == ST_IDLE) && (res_q == $past(partial)))
		else $error("abort did not save partial result");
	abort_flag_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		abort_seq |=> !$rose(stat_q[`APC_ST_CONV]) && !$rose(stat_q[`APC_ST_THR]))
		else $error("abort raised a flag");
	pin_pol_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		pre_seq |=> (cap_level_o != $past(pol)) && (pin_o == ($past(pol) && !$past(pcfg_q.precharge_cap_only))))
		else $error("precharge levels wrong");
	inv_pre_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		pre_seq and (second_q && pcfg_q.double_sample_enable && pcfg_q.inverted_precharge_enable) |=> cap_level_o == $past(pcfg_q.precharge_polarity))
		else $error("second cycle not inverted");
	guard_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		pre_seq and !second_q |=> guard_o == $past(pcfg_q.guard_polarity))
		else $error("guard start level wrong");
	cap_only_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		pre_seq |=> pin_oe_o == !$past(pcfg_q.precharge_cap_only) && cap_pre_o)
		else $error("pin precharge scope wrong");
	pcfg_gap_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		reg_idx(rd_addr) == `APC_IDX_PCFG |-> rd_data[4:2] == 3'h0)
		else $error("unused config bits read nonzero");
	pair_calc_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		thr_hit |-> (!pcfg_q.double_sample_enable || second_q))
		else $error("computation ran mid pair");
	continuous_enable_retrig_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		pair_end && continuous_enable_q && !soi_q |=> go_q && state_q != ST_IDLE)
		else $error("continuous mode failed to retrigger");
endmodule : apc_top

// File: apc_pin_model.sv
`timescale 1ns/1ps
// far side: analog pin, sample capacitor and comparator
module apc_pin_model
(
	input wire logic ref_clk_i,
	input wire logic [9:0] level_i, // pin voltage as a code
	input wire logic [9:0] sar_code_i,
	input wire logic sample_i,
	output logic comp_o
);
	// charge kept on the capacitor; starts empty, never unknown
	logic [9:0] hold_q = 10'h000;

	////////////////////////////////////////////////////////////////
	// the capacitor tracks the pin only while the switch is closed
	always_ff @(posedge ref_clk_i)
	begin
		if (sample_i)
		begin
			hold_q <= level_i;
		end
	end

	// comparator: high keeps the trial bit
	assign comp_o = (hold_q >= sar_code_i);
endmodule : apc_pin_model

// File: tb.sv
`timescale 1ns/1ps
`include "apc_defs.svh"
module tb;
	localparam logic [17:0] A_CTRL = {`APC_IDX_CTRL, 2'h0};
	localparam logic [17:0] A_PCFG = {`APC_IDX_PCFG, 2'h0};
	localparam logic [17:0] A_CFG3 = {`APC_IDX_CFG3, 2'h0};
	localparam logic [17:0] A_PRET = {`APC_IDX_PRET, 2'h0};
	localparam logic [17:0] A_RES = {`APC_IDX_RES, 2'h0};
	localparam logic [17:0] A_THR = {`APC_IDX_THR, 2'h0};
	localparam logic [17:0] A_STAT = {`APC_IDX_STAT, 2'h0};
	localparam logic [17:0] A_MASK = {`APC_IDX_MASK, 2'h0};
	logic clk, rstn, awv, awr, wv, wrd, bv, bre, arv, arr, rv, rre;
	logic [17:0] awa, ara;
	logic [31:0] wd, rdt, d;
	logic [3:0] ws;
	logic [1:0] br, rr, rsp;
	logic comp, smp, cpre, clev, pin, poe, grd, irq;
	logic [9:0] code, lvl;
	logic [3:0] snap [0:3]; // {pin_oe, pin, cap level, guard} per precharge
	logic pre_d;
	int npre, n_fail, n_tests;

	apc_top #(.CLK_DIV(4), .ACQ_TICKS(2)) dut (.ref_clk_i(clk), .resetn_i(rstn),
		.s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awa),
		.s_axi_wvalid_i(wv), .s_axi_wready_o(wrd), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws),
		.s_axi_bvalid_o(bv), .s_axi_bready_i(bre), .s_axi_bresp_o(br),
		.s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_araddr_i(ara),
		.s_axi_rvalid_o(rv), .s_axi_rready_i(rre), .s_axi_rdata_o(rdt), .s_axi_rresp_o(rr),
		.comp_i(comp), .sar_code_o(code), .sample_o(smp), .cap_pre_o(cpre),
		.cap_level_o(clev), .pin_o(pin), .pin_oe_o(poe), .guard_o(grd), .irq_o(irq));
	apc_pin_model pm (.ref_clk_i(clk), .level_i(lvl), .sar_code_i(code), .sample_i(smp), .comp_o(comp));

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////
	// snapshot the pin side at the first cycle of each precharge
	always @(posedge clk)
	begin
		if (cpre && !pre_d)
		begin
			snap[npre[1:0]] = {poe, pin, clev, grd};
			npre++;
		end
		pre_d = cpre;
	end

	////////////////////////////////////////////////////////////////
	task automatic results();
		$display("tests %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results

	// a wait ran out: counted as a mismatch, then the report
	task automatic tmo();
		n_fail++;
		$display("CHECK FAILED wait expected done seen timeout");
		results();
	endtask : tmo

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	// address and data offered together, each dropped once taken
	task automatic wr(input logic [17:0] a, input logic [31:0] v);
		int n;
		n = 0;
		@(posedge clk);
		awv <= 1'b1;
		awa <= a;
		wv <= 1'b1;
		wd <= v;
		ws <= 4'hF;
		bre <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wrd) wv <= 1'b0;
			n++;
			if (n > 500) tmo();
		end while (bv !== 1'b1);
		// response code taken at the edge that accepts it
		rsp = br;
		bre <= 1'b0;
	endtask : wr

	task automatic rd(input logic [17:0] a, output logic [31:0] v);
		int n;
		n = 0;
		@(posedge clk);
		arv <= 1'b1;
		ara <= a;
		rre <= 1'b1;
		do
		begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
			n++;
			if (n > 500) tmo();
		end while (rv !== 1'b1);
		v = rdt;
		rsp = rr;
		rre <= 1'b0;
	endtask : rd

	// poll the go bit until the sequencer reports done
	task automatic idle();
		logic [31:0] g;
		for (int i = 0; i < 300; i++)
		begin
			rd(A_CTRL, g);
			if (g[0] === 1'b0) return;
		end
		tmo();
	endtask : idle

	////////////////////////////////////////////////////////////////
	initial
	begin
		{rstn, awv, wv, bre, arv, rre, awa, ara, wd, ws, pre_d} = '0;
		lvl = 10'h2A5;
		npre = 0;
		n_fail = 0;
		n_tests = 0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		// register file, unused bits, unmapped place
		rd(A_PCFG, d);
		chk("pcfg_rst", d, 32'h0);
		wr(A_PCFG, 32'hFF);
		chk("pcfg_bresp", {30'h0, rsp}, 32'h0);
		rd(A_PCFG, d);
		chk("pcfg_rw", d, 32'hE3);
		rd(18'h00010, d);
		chk("unmapped", {30'h0, rsp}, 32'h2);
		wr(18'h00010, 32'hFF);
		chk("unmapped_w", {30'h0, rsp}, 32'h2);
		// go without the module switched on is ignored
		wr(A_PCFG, 32'h0);
		wr(A_CTRL, 32'h1);
		rd(A_CTRL, d);
		chk("go_off", d, 32'h0);
		// single conversion, pin to supply, guard high, threshold out of reach
		wr(A_MASK, 32'h3);
		wr(A_PRET, 32'h3);
		wr(A_THR, 32'h3FF);
		wr(A_PCFG, 32'hA0);
		npre = 0;
		wr(A_CTRL, 32'h80);
		wr(A_CTRL, 32'h81);
		idle();
		chk("npre1", npre, 1);
		chk("pre_pin", snap[0], 32'hD);
		rd(A_RES, d);
		chk("result", d, 32'h2A5);
		chk("irq_set", irq, 1'b1);
		rd(A_STAT, d);
		chk("stat_conv", d, 32'h1);
		repeat (2) @(posedge clk);
		chk("irq_clr", irq, 1'b0);
		// double sample, inverted second cycle, capacitor only
		wr(A_PCFG, 32'h43);
		npre = 0;
		wr(A_CTRL, 32'h81);
		idle();
		chk("npre2", npre, 2);
		chk("pre_first", snap[0], 32'h2);
		chk("pre_second", snap[1], 32'h1);
		rd(A_STAT, d);
		chk("stat_pair", d, 32'h1);
		// zero precharge time: no precharge stage at all
		wr(A_PRET, 32'h0);
		wr(A_PCFG, 32'h80);
		npre = 0;
		wr(A_CTRL, 32'h81);
		idle();
		chk("npre0", npre, 0);
		rd(A_STAT, d);
		// abort in a long precharge: partial result, no flag
		wr(A_PRET, 32'h32);
		wr(A_CTRL, 32'h81);
		repeat (20) @(posedge clk);
		wr(A_CTRL, 32'h80);
		rd(A_CTRL, d);
		chk("abort_go", d, 32'h80);
		chk("abort_idle", {smp, cpre}, 2'h0);
		rd(A_RES, d);
		chk("abort_res", d, 32'h0);
		chk("abort_irq", irq, 1'b0);
		rd(A_STAT, d);
		chk("abort_stat", d, 32'h0);
		// continuous without stop on interrupt: retriggers until software clears go
		wr(A_PRET, 32'h1);
		wr(A_THR, 32'h0);
		npre = 0;
		wr(A_CTRL, 32'hC1);
		repeat (150) @(posedge clk);
		wr(A_CTRL, 32'hC0);
		chk("continuous_enable_retrig", npre > 1, 1);
		rd(A_CTRL, d);
		chk("continuous_enable_abort_go", d, 32'hC0);
		rd(A_STAT, d);
		chk("continuous_enable_flags", d, 32'h3);
		// continuous with stop on threshold: stops after one
		wr(A_CFG3, 32'h8);
		npre = 0;
		wr(A_CTRL, 32'hC1);
		idle();
		chk("continuous_enable_npre", npre, 1);
		rd(A_STAT, d);
		chk("continuous_enable_stat", d, 32'h3);
		results();
	end
endmodule : tb
